// File: logic/aoc_pkg.sv
// constants shared by the converter output model and its sample store
// assumes one 200 MHz system clock; the sample clock arrives as a plain input
package aoc_pkg;
  localparam int CHANNELS = 8;
  localparam int CODE_W = 10;
  localparam int WORD_W = CHANNELS * CODE_W;
  // latency in sample clock cycles, two pipeline steps per cycle
  localparam int LATENCY_CYCLES = 7;
  localparam int HALF_STEPS = 2 * LATENCY_CYCLES;
  localparam int ADDR_W = 4;
  localparam int DEPTH = 16;
  localparam logic [ADDR_W-1:0] PTR_ONE = 4'h1;
  // read slot lies HALF_STEPS behind the write slot, modulo DEPTH
  localparam logic [ADDR_W-1:0] RD_OFFSET = 4'(DEPTH - HALF_STEPS);
  localparam logic [ADDR_W-1:0] FILL_FULL = 4'(HALF_STEPS);
  localparam logic [ADDR_W-1:0] PTR_RESET = 4'h0;
  localparam logic [CODE_W-1:0] CODE_RESET = 10'h000;
  localparam logic [CODE_W-1:0] SOB_MSB = 10'h200;
  // clock rate and lowest sample rate
  localparam longint CLK_HZ = 200000000;
  localparam longint MIN_RATE_HZ = 1000000;
  localparam int MAX_PERIOD_CYCLES = int'(CLK_HZ / MIN_RATE_HZ);
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
  // duty cycle windows in percent
  localparam int DUTY_TIGHT_MIN = 48;
  localparam int DUTY_TIGHT_MAX = 52;
  localparam int DUTY_WIDE_MIN = 30;
  localparam int DUTY_WIDE_MAX = 70;
  localparam int PERCENT = 100;
  typedef logic [CHANNELS-1:0][CODE_W-1:0] aoc_bus_type;
endpackage

// File: logic/aoc_mem_if.sv
// carrier between the converter control and its sample store
// assumes both ends share one clock
`timescale 1ns/100ps
interface aoc_mem_if;
  import aoc_pkg::*;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [WORD_W-1:0] wr_data;
  logic [ADDR_W-1:0] rd_addr;
  logic [WORD_W-1:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// File: logic/aoc_sample_mem.sv
// small store holding one word of all channels per pipeline step
// assumes read and write never hit the same slot in one cycle
`timescale 1ns/100ps
module aoc_sample_mem (
  // clock
  input wire logic clk,
  // port
  aoc_mem_if.store mp
);
  import aoc_pkg::*;
  logic [WORD_W-1:0] arr [DEPTH];
  logic [WORD_W-1:0] rd_data_r;
  logic [WORD_W-1:0] rd_data_nxt;

  always_comb begin
    rd_data_nxt = arr[mp.rd_addr];
  end

  // no reset on the array: contents are gated by the fill count upstream
  always_ff @(posedge clk) begin
    if (mp.wr_en) begin
      arr[mp.wr_addr] <= mp.wr_data;
    end
    rd_data_r <= rd_data_nxt;
  end

  assign mp.rd_data = rd_data_r;
endmodule

// File: logic/aoc_ctrl.sv
// digital control and output side of an eight channel sampling converter
// assumes sample_clk and all pins are synchronous to clk and far slower than it
`timescale 1ns/100ps
// What this block does
// RQ1: reference disable low enables internal reference
// RQ2: disable high: external mode, buffers off
// RQ3: select low bypasses conditioning, 48-52% clock
// RQ4: select high enables conditioning, 30-70% clock
// RQ5: pipeline steps on both sample clock edges
// RQ6: source keeps sample rate at least 1MSPS
// RQ7: straight offset binary, msb on line nine
// RQ8: zero maps to 10 0000 0000
// RQ9: enable low drives all eight buses
// RQ10: enable high releases all eight buses
// RQ11: controller always drives the enable pin
// RQ12: seven cycle latency, channels updated together
// RQ13: enable changes never disturb pipeline timing
module aoc_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // mode pins
  input wire logic internal_reference_disable,
  input wire logic duty_cycle_adjust_select,
  // sample clock and converted inputs, two's complement per channel
  input wire logic sample_clk,
  input wire aoc_pkg::aoc_bus_type analog_code,
  // output enable, active low
  input wire logic output_enable_n,
  // analog control
  output logic reference_enable,
  output logic ref_buffer_enable,
  output logic clock_conditioning_enable,
  // output buses
  output aoc_pkg::aoc_bus_type data_out,
  output logic data_oe,
  // clock health
  output logic duty_fault,
  output logic rate_fault
);
  import aoc_pkg::*;

  function automatic logic [CODE_W-1:0] to_sob(input logic [CODE_W-1:0] code);
    to_sob = code ^ SOB_MSB;
  endfunction

  function automatic logic duty_ok(input logic [CNT_W-1:0] hi, input logic [CNT_W-1:0] lo,
                                   input int min_pct, input int max_pct);
    logic [31:0] per;
    logic [31:0] hi100;
    per = 32'(hi) + 32'(lo);
    hi100 = 32'(hi) * 32'(PERCENT);
    duty_ok = (hi100 >= 32'(min_pct) * per) && (hi100 <= 32'(max_pct) * per);
  endfunction

  aoc_mem_if mif ();
  aoc_sample_mem u_mem (
    .clk (clk),
    .mp (mif.store)
  );

  logic smp_r;
  logic rise;
  logic fall;
  logic step;
  logic [ADDR_W-1:0] wptr_r;
  logic [ADDR_W-1:0] wptr_nxt;
  logic [ADDR_W-1:0] fill_r;
  logic [ADDR_W-1:0] fill_nxt;
  logic upd_r;
  logic upd_nxt;
  aoc_bus_type data_r;
  aoc_bus_type data_nxt;
  aoc_bus_type sob_word;
  logic oe_r;
  logic ref_en_r;
  logic cond_en_r;
  logic [CNT_W-1:0] hi_cnt_r;
  logic [CNT_W-1:0] hi_cnt_nxt;
  logic [CNT_W-1:0] lo_cnt_r;
  logic [CNT_W-1:0] lo_cnt_nxt;
  logic duty_fault_r;
  logic duty_fault_nxt;
  logic rate_fault_r;
  logic rate_fault_nxt;
  logic slow;
  logic live_r;

  assign rise = sample_clk && !smp_r;
  assign fall = !sample_clk && smp_r;
  assign step = rise || fall;

  // pipeline: one slot per clock edge, samples enter on both edges, only rising-edge slots reach the outputs
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      sob_word[c] = to_sob(analog_code[c]); // RQ7 RQ8
    end
    mif.wr_en = step; // RQ5
    mif.wr_addr = wptr_r;
    mif.wr_data = sob_word;
    mif.rd_addr = 4'(wptr_r + RD_OFFSET); // RQ12
    wptr_nxt = step ? 4'(wptr_r + PTR_ONE) : wptr_r; // RQ5
    fill_nxt = (step && fill_r != FILL_FULL) ? 4'(fill_r + PTR_ONE) : fill_r;
    // slot fourteen edges back has the same parity, so it is a rising-edge sample
    upd_nxt = rise && fill_r == FILL_FULL; // RQ12
    // all channels move as one word
    data_nxt = upd_r ? aoc_bus_type'(mif.rd_data) : data_r; // RQ12
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      smp_r <= 1'b0;
      wptr_r <= PTR_RESET;
      fill_r <= PTR_RESET;
      upd_r <= 1'b0;
      data_r <= '0;
      live_r <= 1'b0;
    end else begin
      smp_r <= sample_clk;
      wptr_r <= wptr_nxt;
      fill_r <= fill_nxt;
      upd_r <= upd_nxt;
      data_r <= data_nxt;
      live_r <= 1'b1;
    end
  end

  // clock health: high and low times measured in system clocks
  always_comb begin
    hi_cnt_nxt = hi_cnt_r;
    lo_cnt_nxt = lo_cnt_r;
    if (rise) begin
      hi_cnt_nxt = 16'h0001;
      lo_cnt_nxt = 16'h0000;
    end else if (sample_clk && hi_cnt_r != CNT_MAX) begin
      hi_cnt_nxt = 16'(hi_cnt_r + 16'h0001);
    end else if (!sample_clk && lo_cnt_r != CNT_MAX) begin
      lo_cnt_nxt = 16'(lo_cnt_r + 16'h0001);
    end
    slow = (32'(hi_cnt_r) + 32'(lo_cnt_r)) > 32'(MAX_PERIOD_CYCLES);
    rate_fault_nxt = rise ? slow : (rate_fault_r || slow); // RQ6
    duty_fault_nxt = duty_fault_r;
    if (rise) begin
      if (cond_en_r) begin
        duty_fault_nxt = !duty_ok(hi_cnt_r, lo_cnt_r, DUTY_WIDE_MIN, DUTY_WIDE_MAX); // RQ4
      end else begin
        duty_fault_nxt = !duty_ok(hi_cnt_r, lo_cnt_r, DUTY_TIGHT_MIN, DUTY_TIGHT_MAX); // RQ3
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hi_cnt_r <= 16'h0000;
      lo_cnt_r <= 16'h0000;
      duty_fault_r <= 1'b0;
      rate_fault_r <= 1'b0;
      oe_r <= 1'b0;
      ref_en_r <= 1'b0;
      cond_en_r <= 1'b0;
    end else begin
      hi_cnt_r <= hi_cnt_nxt;
      lo_cnt_r <= lo_cnt_nxt;
      duty_fault_r <= duty_fault_nxt;
      rate_fault_r <= rate_fault_nxt;
      // enable only gates the drivers, the pipeline never sees it
      oe_r <= !output_enable_n; // RQ9 RQ10 RQ13
      ref_en_r <= !internal_reference_disable; // RQ1 RQ2
      cond_en_r <= duty_cycle_adjust_select; // RQ3 RQ4
    end
  end

  assign reference_enable = ref_en_r;
  assign ref_buffer_enable = ref_en_r;
  assign clock_conditioning_enable = cond_en_r;
  assign data_out = data_r;
  assign data_oe = oe_r;
  assign duty_fault = duty_fault_r;
  assign rate_fault = rate_fault_r;

  default clocking cb @(posedge clk); endclocking
  // the release edge still shows reset values, so checks start one edge later
  default disable iff (!rst_n || !live_r);

  sequence s_sample_taken;
    rise && fill_r == FILL_FULL;
  endsequence

  sequence s_word_fetched;
    ##1 upd_r;
  endsequence

  AST_REF_INT: assert property (!internal_reference_disable |=> reference_enable) // RQ1
    else $error("internal reference not enabled");
  AST_REF_EXT: assert property (internal_reference_disable |=> // RQ2
    !reference_enable && !ref_buffer_enable)
    else $error("reference buffers still on in external mode");
  AST_COND_OFF: assert property (!duty_cycle_adjust_select |=> !clock_conditioning_enable) // RQ3
    else $error("conditioning not bypassed");
  AST_COND_ON: assert property (duty_cycle_adjust_select |=> clock_conditioning_enable) // RQ4
    else $error("conditioning not enabled");
  AST_BOTH_EDGES: assert property (fall |=> wptr_r == 4'($past(wptr_r) + PTR_ONE)) // RQ5
    else $error("falling edge did not advance pipeline");
  // only the sign bit flips, the lower bits pass through
  AST_SOB: assert property (step |-> mif.wr_data[CODE_W-1] != analog_code[0][CODE_W-1] // RQ8
    && mif.wr_data[CODE_W-2:0] == analog_code[0][CODE_W-2:0])
    else $error("offset binary conversion wrong");
  AST_LATENCY: assert property (s_sample_taken ##0 s_word_fetched |=> // RQ12
    data_out == aoc_bus_type'($past(mif.rd_data)))
    else $error("output word not updated after fourteen edges");
  AST_OE_ON: assert property (!output_enable_n |=> data_oe) // RQ9
    else $error("outputs not driven");
  AST_OE_OFF: assert property (output_enable_n |=> !data_oe) // RQ10
    else $error("outputs not released");
  AST_OE_TIMING: assert property ($changed(output_enable_n) && !step |=> $stable(wptr_r)) // RQ13
    else $error("enable change disturbed pipeline");
  AST_OUT_HOLD: assert property (!upd_r |=> $stable(data_out)) // RQ12
    else $error("output word moved without a fetched sample");
  AST_FALL_QUIET: assert property (fall |=> !upd_r) // RQ12
    else $error("falling edge scheduled an output update");
endmodule

// File: testbench/aoc_capture_model.sv
// far side model: sample clock source and capture side of the output buses
// assumes the bench sets the phase lengths in clk cycles, at least 2 each
`timescale 1ns/100ps
module aoc_capture_model (
  // clock
  input wire logic clk,
  // clock shape
  input wire logic [7:0] high_cyc,
  input wire logic [7:0] low_cyc,
  output logic sample_clk,
  // output buses
  input wire aoc_pkg::aoc_bus_type data_out,
  input wire logic data_oe,
  output aoc_pkg::aoc_bus_type bus
);
  import aoc_pkg::*;
  logic [7:0] cnt_r = 8'h00;
  logic clk_r = 1'b0;
  aoc_bus_type last_r = '0;
  // duty and period follow the bench, so a scenario can leave the legal window
  always @(posedge clk) begin
    cnt_r <= cnt_r + 8'h01;
    if (cnt_r + 8'h01 >= (clk_r ? high_cyc : low_cyc)) begin
      clk_r <= ~clk_r;
      cnt_r <= 8'h00;
    end
    if (data_oe) begin
      last_r <= data_out;
    end
  end
  assign sample_clk = clk_r;
  // no pull resistors: a released bus shows the inverse of the last word
  assign bus = data_oe ? data_out : ~last_r;
endmodule

// File: testbench/testbench.sv
// self checking bench for the converter control block
// assumes the capture model supplies the sample clock
`timescale 1ns/100ps
module testbench;
  import aoc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic internal_reference_disable = 1'b0;
  logic duty_cycle_adjust_select = 1'b0;
  logic output_enable_n = 1'b0;
  logic sample_clk, reference_enable, ref_buffer_enable, clock_conditioning_enable;
  logic data_oe, duty_fault, rate_fault;
  logic prev_s = 1'b0;
  logic [7:0] high_cyc = 8'h04;
  logic [7:0] low_cyc = 8'h04;
  aoc_bus_type analog_code, data_out, bus;
  logic [CODE_W-1:0] tin [5] = '{10'h1ff, 10'h100, 10'h000, 10'h300, 10'h200};
  logic [CODE_W-1:0] texp [5] = '{10'h3ff, 10'h300, 10'h200, 10'h100, 10'h000};
  int num_errors = 0;
  int compares = 0;
  aoc_ctrl DUT (.clk, .rst_n, .internal_reference_disable, .duty_cycle_adjust_select,
    .sample_clk, .analog_code, .output_enable_n, .reference_enable, .ref_buffer_enable,
    .clock_conditioning_enable, .data_out, .data_oe, .duty_fault, .rate_fault);
  aoc_capture_model partner (.clk, .high_cyc, .low_cyc, .sample_clk, .data_out, .data_oe,
    .bus);
  always #2.5 clk = ~clk;
  always @(posedge clk) prev_s <= sample_clk;
  function automatic aoc_bus_type word(input int i, input bit e);
    aoc_bus_type w;
    for (int c = 0; c < CHANNELS; c++) w[c] = e ? texp[(i + c) % 5] : tin[(i + c) % 5];
    return w;
  endfunction
  task automatic close_out();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    check(WORD_W'(got), WORD_W'(exp));
  endtask
  // a rise is the edge where the sampled clock is high after a low sample
  task automatic wait_rise(input int count);
    logic hit;
    for (int r = 0; r < count; r++) begin
      hit = 1'b0;
      for (int n = 0; n < 600 && !hit; n++) begin
        @(posedge clk);
        hit = sample_clk && !prev_s;
      end
      if (!hit) begin
        num_errors++;
        $display("MISMATCH %0t no sample clock rise", $time);
        close_out();
      end
    end
  endtask
  initial begin
    analog_code = word(0, 1'b0);
    repeat (3) @(posedge clk);
    #1;
    check_bit(data_oe, 1'b0);
    check_bit(reference_enable, 1'b0);
    @(posedge clk);
    rst_n <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      internal_reference_disable <= m[0];
      duty_cycle_adjust_select <= m[1];
      @(posedge clk);
      #1;
      check_bit(reference_enable, !m[0]);
      check_bit(ref_buffer_enable, !m[0]);
      check_bit(clock_conditioning_enable, m[1]);
    end
    // rows of the code table cycle across samples and channels
    for (int i = 0; i < 24; i++) begin
      wait_rise(1);
      analog_code <= word(i + 1, 1'b0);
      output_enable_n <= (i >= 12 && i < 15);
      if (i >= 7) begin
        repeat (2) @(posedge clk);
        #1;
        if (output_enable_n) check_bit(data_oe, 1'b0);
        else check(bus, word(i - 7, 1'b1));
      end
    end
    check_bit(duty_fault, 1'b0);
    check_bit(rate_fault, 1'b0);
    @(posedge clk);
    duty_cycle_adjust_select <= 1'b0;
    high_cyc <= 8'h06;
    wait_rise(3);
    #1;
    check_bit(duty_fault, 1'b1);
    @(posedge clk);
    duty_cycle_adjust_select <= 1'b1;
    wait_rise(3);
    #1;
    check_bit(duty_fault, 1'b0);
    @(posedge clk);
    high_cyc <= 8'h78;
    low_cyc <= 8'h78;
    wait_rise(3);
    #1;
    check_bit(rate_fault, 1'b1);
    @(posedge clk);
    high_cyc <= 8'h04;
    low_cyc <= 8'h04;
    wait_rise(3);
    #1;
    check_bit(rate_fault, 1'b0);
    close_out();
  end
endmodule
